// ---- design/acf_pkg.sv ----
// Purpose: shared constants and types for the converter control and result format block
// Assumes: 32-bit APB, one aligned word per register, 8-bit register data in the low bits
// Notes: register offsets are byte addresses
package acf_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_STAT = 8'h00;
	localparam logic [7:0] OFS_RHI = 8'h04;
	localparam logic [7:0] OFS_RLO = 8'h08;
	localparam logic [7:0] OFS_CLK = 8'h0c;

	// converter_status_control fields
	localparam int STAT_FLAG_BIT = 7;
	localparam int STAT_IEN_BIT = 6;
	localparam int STAT_CONT_BIT = 5;
	localparam int STAT_CH_LSB = 0;

	// converter_clock_format fields
	localparam int CLK_DIV_LSB = 5;
	localparam int CLK_SRC_BIT = 4;
	localparam int CLK_MODE_LSB = 2;

	// values after reset
	localparam logic [4:0] CH_RST = 5'h1f;
	localparam logic [2:0] DIV_RST = 3'h0;
	localparam logic SRC_RST = 1'b0;
	localparam logic [1:0] MODE_RST = 2'h1;

	// channel codes
	localparam logic [4:0] CH_PIN_LAST = 5'h07;
	localparam logic [4:0] CH_TEST = 5'h1b;
	localparam logic [4:0] CH_VREF_HI = 5'h1d;
	localparam logic [4:0] CH_VREF_LO = 5'h1e;
	localparam logic [4:0] CH_OFF = 5'h1f;

	// result formats
	localparam logic [1:0] FMT_TRUNC = 2'h0;
	localparam logic [1:0] FMT_RIGHT = 2'h1;
	localparam logic [1:0] FMT_LEFT = 2'h2;
	localparam logic [1:0] FMT_SIGNED = 2'h3;

	// full converter clock cycles per conversion, after the alignment cycle
	localparam logic [4:0] CONV_CYCLES = 5'h10;
	localparam logic [4:0] CONV_LAST = CONV_CYCLES - 5'h01;

	typedef enum logic [1:0] {ACF_IDLE, ACF_ALIGN, ACF_CONV} acf_state_e;
endpackage

// ---- design/acf_ctrl.sv ----
// Purpose: control, clocking and result formatting for a 10-bit successive-approximation converter
// Assumes: APB slave on mclk_i; analog result and external reference clock arrive asynchronously
// Notes: one wait state on every APB access; registers hold 8 bits in the low byte of each word
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module acf_ctrl
	import acf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic external_reference_clock_i,
	input wire logic [9:0] conv_data_i,
	output logic [4:0] channel_select_o,
	output logic power_down_o,
	output logic convert_o,
	output logic conv_tick_o,
	output logic irq_o
);
	acf_state_e state_r, state_nxt;
	logic [4:0] ch_r, ch_nxt;
	logic cont_r, cont_nxt;
	logic ien_r, ien_nxt;
	logic flag_r, flag_nxt;
	logic src_r, src_nxt;
	logic [2:0] div_r, div_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [3:0] pcnt_r, pcnt_nxt;
	logic [9:0] res_r, res_nxt;
	logic lock_r, lock_nxt;
	logic first_r, first_nxt;
	logic stab_r, stab_nxt;
	logic irq_r, irq_nxt;
	logic tick_r, tick_nxt;
	logic pwr_r, pwr_nxt;
	logic conv_r, conv_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic ref_s1_r, ref_s2_r, ref_s3_r;
	logic [9:0] dat_s1_r, dat_s2_r;

	logic acc, wr_done, rd_done, stat_wr, clk_wr, rlo_rd, rhi_rd, setup_acc;
	logic in_tick, tick, end_evt, live_end, store, hi_pend;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFS_STAT) || (a == OFS_RHI) || (a == OFS_RLO) || (a == OFS_CLK);
	endfunction

	// last prescaler count for the selected division
	function automatic logic [3:0] div_last(input logic [2:0] d);
		if (d[2]) begin
			div_last = 4'hf;
		end else begin
			case (d[1:0])
				2'h0: div_last = 4'h0;
				2'h1: div_last = 4'h1;
				2'h2: div_last = 4'h3;
				default: div_last = 4'h7;
			endcase
		end
	endfunction

	function automatic logic [7:0] fmt_hi(input logic [9:0] r, input logic [1:0] m);
		case (m)
			FMT_TRUNC: fmt_hi = 8'h00;
			FMT_RIGHT: fmt_hi = {6'h00, r[9:8]};
			FMT_LEFT: fmt_hi = r[9:2];
			default: fmt_hi = {~r[9], r[8:2]};
		endcase
	endfunction

	function automatic logic [7:0] fmt_lo(input logic [9:0] r, input logic [1:0] m);
		case (m)
			FMT_TRUNC: fmt_lo = r[9:2];
			FMT_RIGHT: fmt_lo = r[7:0];
			default: fmt_lo = {r[1:0], 6'h00};
		endcase
	endfunction

	function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [9:0] r, input logic [1:0] m,
			input logic [7:0] st, input logic [7:0] ck);
		case (a)
			OFS_STAT: rd_mux = st;
			OFS_RHI: rd_mux = fmt_hi(r, m);
			OFS_RLO: rd_mux = fmt_lo(r, m);
			OFS_CLK: rd_mux = ck;
			default: rd_mux = 8'h00;
		endcase
	endfunction

	// transfer completes at the edge where pready is seen high
	assign acc = psel_i && penable_i && pready_r;
	assign setup_acc = psel_i && penable_i && !pready_r;
	assign wr_done = acc && pwrite_i;
	assign rd_done = acc && !pwrite_i;
	assign stat_wr = wr_done && (paddr_i == OFS_STAT);
	assign clk_wr = wr_done && (paddr_i == OFS_CLK);
	assign rlo_rd = rd_done && (paddr_i == OFS_RLO);
	assign rhi_rd = rd_done && (paddr_i == OFS_RHI);

	// bus clock every cycle, or rising edges of the synchronised reference
	assign in_tick = src_r ? 1'b1 : (ref_s2_r && !ref_s3_r);
	// compare with >= so a prescale change mid-conversion cannot strand the count past its end
	assign tick = (state_r != ACF_IDLE) && in_tick && (pcnt_r >= div_last(div_r));
	assign end_evt = (state_r == ACF_CONV) && tick && (cnt_r == CONV_LAST) && !stat_wr;
	// a stabilising conversion after power-up never reports
	assign live_end = end_evt && !stab_r;
	// outside truncation format, interlock drops results while the high byte has been read and the low byte not yet;
	// a high-byte read already in flight blocks the store too, so the byte pair stays matched
	assign hi_pend = psel_i && penable_i && !pwrite_i && (paddr_i == OFS_RHI);
	assign store = live_end && !((lock_r || hi_pend) && (mode_r != FMT_TRUNC));

	always_comb begin
		state_nxt = state_r;
		ch_nxt = ch_r;
		cont_nxt = cont_r;
		ien_nxt = ien_r;
		flag_nxt = flag_r;
		src_nxt = src_r;
		div_nxt = div_r;
		mode_nxt = mode_r;
		cnt_nxt = cnt_r;
		pcnt_nxt = pcnt_r;
		res_nxt = res_r;
		lock_nxt = lock_r;
		first_nxt = first_r;
		stab_nxt = stab_r;
		irq_nxt = irq_r;

		if (state_r == ACF_IDLE) begin
			pcnt_nxt = 4'h0;
		end else if (in_tick) begin
			pcnt_nxt = (pcnt_r >= div_last(div_r)) ? 4'h0 : pcnt_r + 4'h1;
		end

		case (state_r)
			ACF_IDLE: begin
				state_nxt = ACF_IDLE;
			end
			ACF_ALIGN: begin
				// partial first converter cycle lines up with the divided clock
				if (tick) begin
					state_nxt = ACF_CONV;
					cnt_nxt = 5'h00;
				end
			end
			ACF_CONV: begin
				if (tick) begin
					if (cnt_r == CONV_LAST) begin
						cnt_nxt = 5'h00;
						if (stab_r) begin
							stab_nxt = 1'b0;
						end else if (!cont_r) begin
							state_nxt = ACF_IDLE;
						end
					end else begin
						cnt_nxt = cnt_r + 5'h01;
					end
				end
			end
			default: begin
				state_nxt = ACF_IDLE;
			end
		endcase

		if (store) begin
			res_nxt = dat_s2_r;
		end

		if (rhi_rd && (mode_r != FMT_TRUNC)) begin
			lock_nxt = 1'b1;
		end
		if (rlo_rd || (mode_r == FMT_TRUNC)) begin
			lock_nxt = 1'b0;
		end

		if (clk_wr) begin
			div_nxt = pwdata_i[CLK_DIV_LSB +: 3];
			src_nxt = pwdata_i[CLK_SRC_BIT];
			mode_nxt = pwdata_i[CLK_MODE_LSB +: 2];
		end

		// with the irq enabled the flag is a plain software bit; otherwise status writes and low-result reads clear it
		if (stat_wr) begin
			flag_nxt = ien_r ? pwdata_i[STAT_FLAG_BIT] : 1'b0;
		end else if (rlo_rd && !ien_r) begin
			flag_nxt = 1'b0;
		end
		if (store && !ien_r && (!cont_r || !first_r)) begin
			flag_nxt = 1'b1;
		end
		if (store) begin
			first_nxt = 1'b1;
		end

		if (stat_wr || rlo_rd) begin
			irq_nxt = 1'b0;
		end
		if (live_end && ien_r) begin
			irq_nxt = 1'b1;
		end

		if (stat_wr) begin
			ch_nxt = pwdata_i[STAT_CH_LSB +: 5];
			cont_nxt = pwdata_i[STAT_CONT_BIT];
			ien_nxt = pwdata_i[STAT_IEN_BIT];
			cnt_nxt = 5'h00;
			pcnt_nxt = 4'h0;
			first_nxt = 1'b0;
			if (pwdata_i[STAT_CH_LSB +: 5] == CH_OFF) begin
				state_nxt = ACF_IDLE;
				stab_nxt = 1'b0;
			end else begin
				state_nxt = ACF_ALIGN;
				if (ch_r == CH_OFF) begin
					stab_nxt = 1'b1;
				end
			end
		end
	end

	always_comb begin
		tick_nxt = tick;
		pwr_nxt = (ch_nxt == CH_OFF);
		conv_nxt = (state_nxt != ACF_IDLE);
		pready_nxt = setup_acc;
		pslverr_nxt = setup_acc && !addr_ok(paddr_i);
		prdata_nxt = 32'h0;
		if (setup_acc && !pwrite_i) begin
			prdata_nxt = {24'h0, rd_mux(paddr_i, res_r, mode_r, {flag_r, ien_r, cont_r, ch_r},
				{div_r, src_r, mode_r, 2'h0})};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_r <= ACF_IDLE;
			ch_r <= CH_RST;
			cont_r <= 1'b0;
			ien_r <= 1'b0;
			flag_r <= 1'b0;
			src_r <= SRC_RST;
			div_r <= DIV_RST;
			mode_r <= MODE_RST;
			cnt_r <= 5'h00;
			pcnt_r <= 4'h0;
			res_r <= 10'h000;
			lock_r <= 1'b0;
			first_r <= 1'b0;
			stab_r <= 1'b0;
			irq_r <= 1'b0;
			tick_r <= 1'b0;
			pwr_r <= 1'b1;
			conv_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_s3_r <= 1'b0;
			dat_s1_r <= 10'h000;
			dat_s2_r <= 10'h000;
		end else begin
			state_r <= state_nxt;
			ch_r <= ch_nxt;
			cont_r <= cont_nxt;
			ien_r <= ien_nxt;
			flag_r <= flag_nxt;
			src_r <= src_nxt;
			div_r <= div_nxt;
			mode_r <= mode_nxt;
			cnt_r <= cnt_nxt;
			pcnt_r <= pcnt_nxt;
			res_r <= res_nxt;
			lock_r <= lock_nxt;
			first_r <= first_nxt;
			stab_r <= stab_nxt;
			irq_r <= irq_nxt;
			tick_r <= tick_nxt;
			pwr_r <= pwr_nxt;
			conv_r <= conv_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			ref_s1_r <= external_reference_clock_i;
			ref_s2_r <= ref_s1_r;
			ref_s3_r <= ref_s2_r;
			dat_s1_r <= conv_data_i;
			dat_s2_r <= dat_s1_r;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign channel_select_o = ch_r;
	assign power_down_o = pwr_r;
	assign convert_o = conv_r;
	assign conv_tick_o = tick_r;
	assign irq_o = irq_r;

	abort_restart_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		stat_wr && (pwdata_i[4:0] != CH_OFF) |=> (state_r == ACF_ALIGN) && (cnt_r == 5'h00))
		else $error("status write did not restart conversion");
	flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		store && !ien_r && !cont_r |=> flag_r)
		else $error("completion flag not set after single conversion");
	flag_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(stat_wr || rlo_rd) && !ien_r && !store |=> !flag_r)
		else $error("completion flag not cleared");
	flag_rw_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		stat_wr && ien_r |=> flag_r == $past(pwdata_i[STAT_FLAG_BIT]))
		else $error("completion flag not writable with irq enabled");
	irq_raise_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		live_end && ien_r |=> irq_o ##1 (irq_o || $past(stat_wr || rlo_rd)))
		else $error("irq not raised at conversion end");
	single_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		live_end && !cont_r |=> !convert_o ##1 (state_r == ACF_IDLE || $past(stat_wr)))
		else $error("single conversion did not stop");
	power_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		stat_wr && (pwdata_i[4:0] == CH_OFF) |=> (state_r == ACF_IDLE) ##1 power_down_o && !convert_o)
		else $error("all-ones channel did not power down");
	stab_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		end_evt && stab_r |=> $stable(res_r) && !irq_o && (state_r == ACF_CONV))
		else $error("stabilising conversion reported a result");
	lock_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		end_evt && lock_r && (mode_r != FMT_TRUNC) |=> $stable(res_r))
		else $error("result changed while interlocked");
	trunc_high_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		setup_acc && !pwrite_i && (paddr_i == OFS_RHI) && (mode_r == FMT_TRUNC) |=> prdata_o == 32'h0)
		else $error("high result not zero in truncation format");
	conv_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ACF_CONV) |-> (cnt_r <= CONV_LAST))
		else $error("conversion ran past its cycle count");
endmodule
`default_nettype wire

// ---- tb/acf_core_model.sv ----
// Purpose: behavioural analog converter core and input multiplexer
// Assumes: result is steady while a channel other than power-off is selected
// Notes: result pattern follows the channel code so each route can be told apart
`timescale 1ns/100ps
`default_nettype none
module acf_core_model (
	input wire logic mclk_i,
	input wire logic [4:0] channel_select_i,
	input wire logic power_down_i,
	output logic [9:0] conv_data_o
);
	logic [9:0] junk_r = 10'h155;
	// a powered-down core holds no value, so the line keeps changing
	always @(posedge mclk_i) begin
		junk_r <= ~junk_r + 10'h001;
	end
	assign conv_data_o = power_down_i ? junk_r : {~channel_select_i, 5'h0a};
endmodule
`default_nettype wire

// ---- tb/test_adc_control_and_result_format.sv ----
// Purpose: self-checking bench for the converter control and result format block
// Assumes: one wait state on APB, bus clock 125 MHz, reference clock 12.5 MHz
// Notes: reset values and a bad-address read run first, then format rows, interlock, continuous, prescaler and power-off cases
`timescale 1ns/100ps
`default_nettype none
module test_adc_control_and_result_format
	import acf_pkg::*;
;
	typedef struct packed {logic [1:0] fmt; logic [7:0] hi; logic [7:0] lo;} acf_row_s;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ext_clk = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, pwr_dn, convert, tick, irq, err;
	logic [4:0] ch_sel;
	logic [9:0] conv_data;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int ticks = 0;
	int t0, n;
	acf_row_s rows [4] = '{'{FMT_TRUNC, 8'h00, 8'he2}, '{FMT_LEFT, 8'he2, 8'h80},
		'{FMT_SIGNED, 8'h62, 8'h80}, '{FMT_RIGHT, 8'h03, 8'h8a}};
	int divs [6] = '{1, 2, 4, 8, 16, 16};
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

	always #4 mclk = ~mclk;
	// reference clock well above 1 MHz, phase unrelated to the bus clock
	initial #3 forever #40 ext_clk = ~ext_clk;

	acf_ctrl DUT (.mclk_i(mclk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.external_reference_clock_i(ext_clk), .conv_data_i(conv_data), .channel_select_o(ch_sel),
		.power_down_o(pwr_dn), .convert_o(convert), .conv_tick_o(tick), .irq_o(irq));
	acf_core_model CORE (.mclk_i(mclk), .channel_select_i(ch_sel), .power_down_i(pwr_dn),
		.conv_data_o(conv_data));

	task give_verdict();
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (tick === 1'b1)
			ticks <= ticks + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task wait_flag();
		int k;
		k = 0;
		do begin
			apb(1'b0, OFS_STAT, 8'h00);
			k++;
		end while (q[7] !== 1'b1 && k < 200);
	endtask

	// cycles between two converter clock ticks
	task gap();
		n = 0;
		while (tick !== 1'b1) @(posedge mclk);
		do begin
			@(posedge mclk);
			n++;
		end while (tick !== 1'b1);
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		apb(1'b0, OFS_STAT, 8'h00);
		chk(q, 32'h1f);
		apb(1'b0, OFS_CLK, 8'h00);
		chk(q, 32'h04);
		chk(32'(pwr_dn), 32'h1);
		apb(1'b0, 8'h10, 8'h00);
		chk(32'(err), 32'h1);
		foreach (rows[i]) begin
			apb(1'b1, OFS_CLK, {3'h0, 1'b1, rows[i].fmt, 2'h0});
			t0 = ticks;
			apb(1'b1, OFS_STAT, 8'h03);
			wait_flag();
			if (i > 0)
				chk(32'(ticks - t0 >= 16 && ticks - t0 <= 17), 32'h1);
			apb(1'b0, OFS_RHI, 8'h00);
			chk(q, {24'h0, rows[i].hi});
			apb(1'b0, OFS_RLO, 8'h00);
			chk(q, {24'h0, rows[i].lo});
			apb(1'b0, OFS_STAT, 8'h00);
			chk(q, 32'h03);
		end
		// high read locks, then a new conversion ends before the low read
		apb(1'b1, OFS_STAT, 8'h03);
		wait_flag();
		apb(1'b0, OFS_RHI, 8'h00);
		apb(1'b1, OFS_STAT, 8'h45);
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(irq), 32'h1);
		apb(1'b0, OFS_RLO, 8'h00);
		chk(q, 32'h8a);
		chk(32'(irq), 32'h0);
		apb(1'b1, OFS_STAT, 8'hc5);
		apb(1'b0, OFS_STAT, 8'h00);
		chk(q, 32'hc5);
		apb(1'b1, OFS_STAT, 8'h23);
		wait_flag();
		repeat (40) @(posedge mclk);
		chk(32'(convert), 32'h1);
		apb(1'b1, OFS_STAT, 8'h03);
		apb(1'b0, OFS_STAT, 8'h00);
		chk(q, 32'h03);
		n = 0;
		while (convert !== 1'b0 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(convert), 32'h0);
		foreach (divs[i]) begin
			apb(1'b1, OFS_CLK, {codes[i], 1'b1, FMT_RIGHT, 2'h0});
			apb(1'b1, OFS_STAT, 8'h03);
			gap();
			chk(32'(n), 32'(divs[i]));
		end
		apb(1'b1, OFS_CLK, {3'h0, 1'b0, FMT_RIGHT, 2'h0});
		apb(1'b1, OFS_STAT, 8'h03);
		gap();
		chk(32'(n >= 9 && n <= 11), 32'h1);
		apb(1'b1, OFS_STAT, 8'h1f);
		chk({25'h0, ch_sel, pwr_dn, convert}, {25'h0, CH_OFF, 2'b10});
		apb(1'b1, OFS_STAT, 8'h1d);
		chk({27'h0, ch_sel}, {27'h0, CH_VREF_HI});
		chk(32'(pwr_dn), 32'h0);
		// leave every field off its reset value, then reset in mid-run
		apb(1'b1, OFS_CLK, 8'hfc);
		apb(1'b1, OFS_STAT, 8'h7d);
		apb(1'b1, OFS_STAT, 8'hfd);
		apb(1'b0, OFS_STAT, 8'h00);
		chk(q, 32'hfd);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk({29'h0, irq, convert, pwr_dn}, 32'h1);
		apb(1'b0, OFS_STAT, 8'h00);
		chk(q, 32'h1f);
		apb(1'b0, OFS_CLK, 8'h00);
		chk(q, 32'h04);
		give_verdict();
	end
endmodule
`default_nettype wire
